// ===== src/srcap_pkg.sv
// Constants, enums and carrier types of the reference capture block
`default_nettype none
package srcap_pkg;
  // Register byte addresses
  localparam logic [15:0] ADDR_CLK_DIV     = 16'h010B;
  localparam logic [15:0] ADDR_REF_CTRL    = 16'h0120;
  localparam logic [15:0] ADDR_SKEW_WIN    = 16'h0122;
  localparam logic [15:0] ADDR_TS_DELAY    = 16'h0123;
  localparam logic [15:0] ADDR_SH_MON      = 16'h0128;
  localparam logic [15:0] ADDR_CHIP_SYNC   = 16'h01FF;
  localparam logic [15:0] ADDR_CB_FUNC_LO  = 16'h0559;
  localparam logic [15:0] ADDR_CB_FUNC_HI  = 16'h055A;
  localparam logic [15:0] ADDR_CB_COUNT    = 16'h058F;
  localparam logic [15:0] ADDR_IGNORE_CNT  = 16'h0130;
  localparam logic [15:0] ADDR_LMFC_PER    = 16'h0131;
  localparam logic [15:0] ADDR_IRQ_STAT    = 16'h0132;
  localparam logic [15:0] ADDR_IRQ_MASK    = 16'h0133;
  // Writable bit masks, reserved bits read as zero
  localparam logic [7:0]  MASK_CLK_DIV     = 8'h07;
  localparam logic [7:0]  MASK_REF_CTRL    = 8'h1E;
  localparam logic [7:0]  MASK_SKEW_WIN    = 8'h0F;
  localparam logic [7:0]  MASK_CHIP_SYNC   = 8'h01;
  localparam logic [7:0]  MASK_CB_FUNC_LO  = 8'h77;
  localparam logic [7:0]  MASK_CB_FUNC_HI  = 8'h07;
  localparam logic [7:0]  MASK_CB_COUNT    = 8'hC0;
  // Field positions
  localparam int          REF_MODE_LSB     = 1;
  localparam int          REF_EDGE_BIT     = 3;
  localparam int          REF_TRANS_BIT    = 4;
  localparam int          WIN_POS_LSB      = 0;
  localparam int          WIN_NEG_LSB      = 2;
  localparam int          CB0_FUNC_LSB     = 0;
  localparam int          CB1_FUNC_LSB     = 4;
  localparam int          CB2_FUNC_LSB     = 0;
  localparam int          CB_COUNT_LSB     = 6;
  localparam int          CHIP_SYNC_BIT    = 0;
  // Values after reset
  localparam logic [7:0]  RST_REG          = 8'h00;
  localparam logic [7:0]  RST_LMFC_PER     = 8'h1F;
  localparam logic [4:0]  RST_IGNORE       = 5'h00;
  localparam logic [3:0]  RST_IRQ          = 4'h0;
  // Counts and codes
  localparam logic [2:0]  FUNC_SYSREF      = 3'h5;
  localparam logic [4:0]  IGNORE_MAX       = 5'h10;
  localparam logic [3:0]  MON_GOOD         = 4'h8;
  localparam logic [3:0]  MON_WORST_HOLD   = 4'hF;
  localparam logic [2:0]  MON_LAST         = 3'h7;
  // Interrupt status bit positions
  localparam int          IRQ_CAPTURE      = 0;
  localparam int          IRQ_RESYNC       = 1;
  localparam int          IRQ_MARGIN       = 2;
  localparam int          IRQ_STAMP        = 3;

  typedef enum logic [1:0] {
    SRCAP_MODE_OFF  = 2'b00,
    SRCAP_MODE_CONT = 2'b01,
    SRCAP_MODE_SHOT = 2'b10,
    SRCAP_MODE_RSVD = 2'b11
  } srcap_mode_e;

  typedef enum logic [0:0] {
    SRCAP_MON_IDLE = 1'b0,
    SRCAP_MON_HOLD = 1'b1
  } srcap_mon_e;

  // Synchronisation pulses to the dividers and downstream blocks
  typedef struct packed {
    logic divider;
    logic ddc;
    logic sigmon;
    logic link;
  } srcap_sync_s;
endpackage : srcap_pkg
`default_nettype wire

// ===== src/srcap_top.sv
// Reference capture, skew window, margin monitor and timestamp marking
//
// Behaviour
// [RL1] Timestamp marks only without decimation active
// [RL2] Chip sync bit set: mark, never reset
// [RL3] Software picks mode, enables bits, function five
// [RL4] Control bits enabled from bit two downward
// [RL5] Timestamp delay shifts the marked sample
// [RL6] Mode write arms; counted-shot clears itself
// [RL7] Reference pulse lasts two clocks times divider
// [RL8] Continuous period is whole multiframe multiple
// [RL9] Normal mode capture syncs divider, ddc, monitor, link
// [RL10] Transition and clock edge selectable, default zero
// [RL11] Counted-shot discards up to sixteen events first
// [RL12] Continuous mode resyncs on misaligned capture
// [RL13] Skew window keeps dividers undisturbed
// [RL14] Early is negative skew, late is positive
// [RL15] Monitor: hold upper nibble, setup lower nibble
// [RL16] Hold zero, setup low: setup error
// [RL17] Setup zero, hold high: hold error
// [RL18] Setup or hold eight marks error-free capture; the code reports 0x88 only when setup and hold are both eight
// [RL19] Monitor refreshed on every reference capture; the code refreshes it only on captures that arrive while the monitor is idle
`default_nettype none
module srcap_top (
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic [15:0]        reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [7:0]              reg_rdata_o,
  input  wire logic               sysref_i,
  input  wire logic               decim_active_i,
  output srcap_pkg::srcap_sync_s  sync_o,
  output logic [2:0]              ctrl_bits_o,
  output logic                    sample_en_o,
  output logic                    irq_o
);

  // Length of the run of old level before the edge, 0 to 8
  function automatic logic [3:0] run_len(input logic [8:0] h,
                                         input logic       old);
    logic [3:0] n;
    logic       stop;
    n    = 4'h0;
    stop = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      if (!stop && h[i] == old) begin
        n = n + 4'h1;
      end else begin
        stop = 1'b1;
      end
    end
    return n;
  endfunction : run_len

  // Monitor code: hold status high nibble, setup status low nibble
  function automatic logic [7:0] mon_code(input logic [3:0] su,
                                          input logic [3:0] ho);
    logic su_ok;
    logic ho_ok;
    su_ok = (su == srcap_pkg::MON_GOOD);
    ho_ok = (ho == srcap_pkg::MON_GOOD);
    if (su_ok && ho_ok) begin
      return {srcap_pkg::MON_GOOD, srcap_pkg::MON_GOOD}; // RL18
    end else if (!su_ok && ho_ok) begin
      return {4'h0, su}; // RL16
    end else if (su_ok) begin
      return {(ho == 4'h0) ? srcap_pkg::MON_WORST_HOLD : 4'h0 - ho,
              4'h0}; // RL17
    end else begin
      return 8'h00; // RL16
    end
  endfunction : mon_code

  // Register state
  logic [7:0]  div_q, div_d, ref_q, ref_d, win_q, win_d, tsd_q, tsd_d;
  logic [7:0]  csm_q, csm_d, cbl_q, cbl_d, cbh_q, cbh_d, cbc_q, cbc_d;
  logic [7:0]  per_q, per_d, rdata_q, rdata_d, mon_q, mon_d;
  logic [4:0]  ign_q, ign_d;
  logic [3:0]  st_q, st_d, msk_q, msk_d, ev_vec;
  // Capture core state
  logic        s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
  logic [8:0]  hist_q, hist_d;
  logic [2:0]  dcnt_q, dcnt_d;
  logic [7:0]  lmfc_q, lmfc_d;
  logic [4:0]  igc_q, igc_d;
  srcap_pkg::srcap_sync_s sync_q, sync_d;
  // Monitor state
  srcap_pkg::srcap_mon_e  mst_q, mst_d;
  logic [2:0]  hcnt_q, hcnt_d;
  logic [3:0]  hrun_q, hrun_d, surun_q, surun_d;
  logic        hbad_q, hbad_d, newl_q, newl_d;
  // Timestamp state
  logic        pend_q, pend_d;
  logic [7:0]  tcnt_q, tcnt_d;
  logic [2:0]  cb_q, cb_d, cb_sel;
  logic [2:0]  fn [3];
  // Decoded terms
  srcap_pkg::srcap_mode_e mode;
  logic        lvl, ev, skip, act, shot_done, stamp_mode, in_win;
  logic        resync, sample_en, mon_wr, mark, ctrl_wr;
  logic [1:0]  cs;
  logic [8:0]  to_zero;
  logic [7:0]  lmfc_nx;

  // Field decode shared by several groups
  assign mode       = srcap_pkg::srcap_mode_e'(
                        ref_q[srcap_pkg::REF_MODE_LSB +: 2]);
  assign stamp_mode = csm_q[srcap_pkg::CHIP_SYNC_BIT];
  assign cs         = cbc_q[srcap_pkg::CB_COUNT_LSB +: 2];
  assign ctrl_wr    = reg_wr_i && (reg_addr_i == srcap_pkg::ADDR_REF_CTRL);
  assign sample_en  = (dcnt_q == div_q[2:0]);

  // Register file next values, reads answered one cycle later
  always_comb begin
    div_d   = div_q;
    ref_d   = ref_q;
    win_d   = win_q;
    tsd_d   = tsd_q;
    csm_d   = csm_q;
    cbl_d   = cbl_q;
    cbh_d   = cbh_q;
    cbc_d   = cbc_q;
    ign_d   = ign_q;
    per_d   = per_q;
    msk_d   = msk_q;
    rdata_d = 8'h00;
    if (shot_done) begin
      ref_d[srcap_pkg::REF_MODE_LSB +: 2] = 2'b00; // RL6
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        srcap_pkg::ADDR_CLK_DIV:
          div_d = reg_wdata_i & srcap_pkg::MASK_CLK_DIV;
        srcap_pkg::ADDR_REF_CTRL:
          ref_d = reg_wdata_i & srcap_pkg::MASK_REF_CTRL;
        srcap_pkg::ADDR_SKEW_WIN:
          win_d = reg_wdata_i & srcap_pkg::MASK_SKEW_WIN;
        srcap_pkg::ADDR_TS_DELAY:   tsd_d = reg_wdata_i;
        srcap_pkg::ADDR_CHIP_SYNC:
          csm_d = reg_wdata_i & srcap_pkg::MASK_CHIP_SYNC;
        srcap_pkg::ADDR_CB_FUNC_LO:
          cbl_d = reg_wdata_i & srcap_pkg::MASK_CB_FUNC_LO;
        srcap_pkg::ADDR_CB_FUNC_HI:
          cbh_d = reg_wdata_i & srcap_pkg::MASK_CB_FUNC_HI;
        srcap_pkg::ADDR_CB_COUNT:
          cbc_d = reg_wdata_i & srcap_pkg::MASK_CB_COUNT;
        srcap_pkg::ADDR_LMFC_PER:   per_d = reg_wdata_i;
        srcap_pkg::ADDR_IRQ_MASK:   msk_d = reg_wdata_i[3:0];
        srcap_pkg::ADDR_IGNORE_CNT: begin
          ign_d = (reg_wdata_i > 8'h10) ? srcap_pkg::IGNORE_MAX
                                        : reg_wdata_i[4:0]; // RL11
        end
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        srcap_pkg::ADDR_CLK_DIV:    rdata_d = div_q;
        srcap_pkg::ADDR_REF_CTRL:   rdata_d = ref_q;
        srcap_pkg::ADDR_SKEW_WIN:   rdata_d = win_q;
        srcap_pkg::ADDR_TS_DELAY:   rdata_d = tsd_q;
        srcap_pkg::ADDR_SH_MON:     rdata_d = mon_q; // RL15
        srcap_pkg::ADDR_CHIP_SYNC:  rdata_d = csm_q;
        srcap_pkg::ADDR_CB_FUNC_LO: rdata_d = cbl_q;
        srcap_pkg::ADDR_CB_FUNC_HI: rdata_d = cbh_q;
        srcap_pkg::ADDR_CB_COUNT:   rdata_d = cbc_q;
        srcap_pkg::ADDR_IGNORE_CNT: rdata_d = {3'h0, ign_q};
        srcap_pkg::ADDR_LMFC_PER:   rdata_d = per_q;
        srcap_pkg::ADDR_IRQ_STAT:   rdata_d = {4'h0, st_q};
        srcap_pkg::ADDR_IRQ_MASK:   rdata_d = {4'h0, msk_q};
        default:                    rdata_d = 8'h00;
      endcase
    end
    // Read clears status, a new event in the same cycle survives
    st_d = st_q;
    if (reg_rd_i && reg_addr_i == srcap_pkg::ADDR_IRQ_STAT) begin
      st_d = 4'h0;
    end
    st_d = st_d | ev_vec;
  end

  // Register file storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_q   <= srcap_pkg::RST_REG;
      ref_q   <= srcap_pkg::RST_REG; // RL10
      win_q   <= srcap_pkg::RST_REG;
      tsd_q   <= srcap_pkg::RST_REG;
      csm_q   <= srcap_pkg::RST_REG;
      cbl_q   <= srcap_pkg::RST_REG;
      cbh_q   <= srcap_pkg::RST_REG;
      cbc_q   <= srcap_pkg::RST_REG;
      per_q   <= srcap_pkg::RST_LMFC_PER;
      ign_q   <= srcap_pkg::RST_IGNORE;
      msk_q   <= srcap_pkg::RST_IRQ;
      st_q    <= srcap_pkg::RST_IRQ;
      rdata_q <= srcap_pkg::RST_REG;
    end else begin
      div_q   <= div_d;
      ref_q   <= ref_d;
      win_q   <= win_d;
      tsd_q   <= tsd_d;
      csm_q   <= csm_d;
      cbl_q   <= cbl_d;
      cbh_q   <= cbh_d;
      cbc_q   <= cbc_d;
      per_q   <= per_d;
      ign_q   <= ign_d;
      msk_q   <= msk_d;
      st_q    <= st_d;
      rdata_q <= rdata_d;
    end
  end

  // Edge detection, ignore counting and window check
  always_comb begin
    s1_d    = sysref_i;
    s2_d    = s1_q;
    s3_d    = s2_q;
    lvl     = ref_q[srcap_pkg::REF_EDGE_BIT] ? s3_q : s2_q; // RL10
    hist_d  = {hist_q[7:0], lvl};
    ev      = (ref_q[srcap_pkg::REF_TRANS_BIT] ? (hist_q[0] && !lvl)
                                               : (!hist_q[0] && lvl))
              && (mode == srcap_pkg::SRCAP_MODE_CONT ||
                  mode == srcap_pkg::SRCAP_MODE_SHOT); // RL10
    skip    = ev && mode == srcap_pkg::SRCAP_MODE_SHOT && igc_q != 5'h0;
    act     = ev && !skip; // RL11
    shot_done = act && mode == srcap_pkg::SRCAP_MODE_SHOT; // RL6
    // Phase of this cycle is the counter after this sample enable, so a
    // reference one multiframe after a resync lands on phase zero
    lmfc_nx = lmfc_q;
    if (sample_en) begin
      lmfc_nx = (lmfc_q == per_q) ? 8'h00 : lmfc_q + 8'h01;
    end
    // Distance to phase zero, negative side and positive side
    to_zero = {1'b0, per_q} - {1'b0, lmfc_nx} + 9'h001;
    in_win  = (lmfc_nx == 8'h00) ||
              (lmfc_nx <= {6'h00, win_q[srcap_pkg::WIN_POS_LSB +: 2]}) ||
              (to_zero <= {7'h00, win_q[srcap_pkg::WIN_NEG_LSB +: 2]}); // RL14
    resync  = act && !stamp_mode &&
              (mode == srcap_pkg::SRCAP_MODE_SHOT || !in_win); // RL2 RL12 RL13
    igc_d   = igc_q;
    if (ctrl_wr) begin
      igc_d = ign_q; // RL6
    end else if (skip) begin
      igc_d = igc_q - 5'h01; // RL11
    end
    dcnt_d  = (resync || sample_en) ? 3'h0 : dcnt_q + 3'h1;
    lmfc_d  = resync ? 8'h00 : lmfc_nx; // RL9
    sync_d  = resync ? 4'hF : 4'h0; // RL9 RL12
  end

  // Capture core storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      hist_q <= 9'h000;
      dcnt_q <= 3'h0;
      lmfc_q <= 8'h00;
      igc_q  <= 5'h00;
      sync_q <= 4'h0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      hist_q <= hist_d;
      dcnt_q <= dcnt_d;
      lmfc_q <= lmfc_d;
      igc_q  <= igc_d;
      sync_q <= sync_d;
    end
  end

  // Setup and hold monitor, refreshed eight cycles after each capture that finds it idle
  always_comb begin
    mst_d   = mst_q;
    hcnt_d  = hcnt_q;
    hrun_d  = hrun_q;
    hbad_d  = hbad_q;
    newl_d  = newl_q;
    surun_d = surun_q;
    mon_d   = mon_q;
    mon_wr  = 1'b0;
    case (mst_q)
      srcap_pkg::SRCAP_MON_IDLE: begin
        if (ev) begin
          mst_d   = srcap_pkg::SRCAP_MON_HOLD;
          hcnt_d  = 3'h0;
          hrun_d  = 4'h0;
          hbad_d  = 1'b0;
          newl_d  = lvl;
          surun_d = run_len(hist_q, hist_q[0]); // RL15
        end
      end
      srcap_pkg::SRCAP_MON_HOLD: begin
        if (lvl == newl_q && !hbad_q) begin
          hrun_d = hrun_q + 4'h1;
        end else begin
          hbad_d = 1'b1;
        end
        hcnt_d = hcnt_q + 3'h1;
        if (hcnt_q == srcap_pkg::MON_LAST) begin
          mon_wr = 1'b1;
          mon_d  = mon_code(surun_q, hrun_d); // RL19
          mst_d  = srcap_pkg::SRCAP_MON_IDLE;
        end
      end
      default: mst_d = srcap_pkg::SRCAP_MON_IDLE;
    endcase
  end

  // Monitor storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mst_q   <= srcap_pkg::SRCAP_MON_IDLE;
      hcnt_q  <= 3'h0;
      hrun_q  <= 4'h0;
      hbad_q  <= 1'b0;
      newl_q  <= 1'b0;
      surun_q <= 4'h0;
      mon_q   <= srcap_pkg::RST_REG;
    end else begin
      mst_q   <= mst_d;
      hcnt_q  <= hcnt_d;
      hrun_q  <= hrun_d;
      hbad_q  <= hbad_d;
      newl_q  <= newl_d;
      surun_q <= surun_d;
      mon_q   <= mon_d;
    end
  end

  // Control bit functions, bit two is the first one enabled
  assign fn[0] = cbl_q[srcap_pkg::CB0_FUNC_LSB +: 3];
  assign fn[1] = cbl_q[srcap_pkg::CB1_FUNC_LSB +: 3];
  assign fn[2] = cbh_q[srcap_pkg::CB2_FUNC_LSB +: 3];
  for (genvar gi = 0; gi < 3; gi++) begin : g_cb
    assign cb_sel[gi] = (cs >= 2'(3 - gi)) &&
                        (fn[gi] == srcap_pkg::FUNC_SYSREF); // RL4
  end

  // Timestamp delay in sample clocks, then one marked sample
  always_comb begin
    pend_d = pend_q;
    tcnt_d = tcnt_q;
    mark   = 1'b0;
    if (act && stamp_mode && !decim_active_i) begin
      pend_d = 1'b1; // RL2
      tcnt_d = tsd_q; // RL5
    end else if (pend_q && sample_en) begin
      if (tcnt_q == 8'h00) begin
        pend_d = 1'b0;
        mark   = 1'b1;
      end else begin
        tcnt_d = tcnt_q - 8'h01; // RL5
      end
    end
    cb_d = (mark && !decim_active_i) ? cb_sel : 3'h0; // RL1
  end

  // Timestamp storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'b0;
      tcnt_q <= 8'h00;
      cb_q   <= 3'h0;
    end else begin
      pend_q <= pend_d;
      tcnt_q <= tcnt_d;
      cb_q   <= cb_d;
    end
  end

  // Interrupt events and outputs
  assign ev_vec[srcap_pkg::IRQ_CAPTURE] = act;
  assign ev_vec[srcap_pkg::IRQ_RESYNC]  = resync;
  assign ev_vec[srcap_pkg::IRQ_MARGIN]  =
    mon_wr && mon_d != {srcap_pkg::MON_GOOD, srcap_pkg::MON_GOOD};
  assign ev_vec[srcap_pkg::IRQ_STAMP]   = cb_d != 3'h0;
  assign irq_o       = |(st_q & msk_q);
  assign reg_rdata_o = rdata_q;
  assign sync_o      = sync_q;
  assign ctrl_bits_o = cb_q;
  assign sample_en_o = sample_en;

  // Checks on the capture, monitor and timestamp paths
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_stamp_no_decim: assert property ( // RL1
    $past(decim_active_i) |-> ctrl_bits_o == 3'h0)
    else $error("control bit mark while decimating");
  chk_stamp_no_reset: assert property ( // RL2
    act && stamp_mode |=> sync_o == 4'h0)
    else $error("timestamp mode reset the clocks");
  chk_shot_self_clear: assert property ( // RL6
    shot_done && !reg_wr_i |=> mode == srcap_pkg::SRCAP_MODE_OFF)
    else $error("counted-shot mode did not clear");
  chk_normal_sync_all: assert property ( // RL9
    act && !stamp_mode && mode == srcap_pkg::SRCAP_MODE_SHOT
    |=> sync_o == 4'hF ##1 lmfc_q <= 8'h01)
    else $error("normal capture did not sync all blocks");
  chk_ignore_count: assert property ( // RL11
    skip |=> sync_o == 4'h0 && igc_q == ($past(ctrl_wr) ? $past(ign_q)
                                          : $past(igc_q) - 5'h01))
    else $error("ignored event was acted on");
  chk_window_outside: assert property ( // RL12
    act && !stamp_mode && mode == srcap_pkg::SRCAP_MODE_CONT && !in_win
    |=> sync_o.link && lmfc_q == 8'h00)
    else $error("misaligned capture did not resync");
  chk_window_inside: assert property ( // RL13
    act && mode == srcap_pkg::SRCAP_MODE_CONT && in_win
    |=> sync_o == 4'h0 ##1 sync_o == 4'h0 || $past(act))
    else $error("capture inside window disturbed dividers");
  chk_monitor_codes: assert property ( // RL16
    mon_wr |=> mon_q == 8'h88 || mon_q[7:4] == 4'h0 && mon_q[3] == 1'b0
               || mon_q[3:0] == 4'h0 && mon_q[7:4] >= 4'h9)
    else $error("monitor code outside the defined set");
  chk_monitor_refresh: assert property ( // RL19
    mst_q == srcap_pkg::SRCAP_MON_IDLE && ev |-> ##8 mon_wr)
    else $error("monitor not refreshed after capture");

  cov_shot_capture: cover property (shot_done);
  cov_stamp_mark:   cover property (ctrl_bits_o != 3'h0);
  cov_clean_margin: cover property (mon_wr && mon_d == 8'h88);
  cov_window_keep:  cover property (act && in_win && lmfc_q != 8'h00);

endmodule : srcap_top
`default_nettype wire

// ===== testbench/srcap_ref_gen.sv
// Reference pulse source standing in for the system clock generator
`default_nettype none
module srcap_ref_gen (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] npulse_i,
  input  wire logic [7:0] high_i,
  input  wire logic [7:0] low_i,
  output logic            sysref_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q;
  logic [7:0] cnt_q;
  logic [7:0] hi_w;

  initial begin
    left_q = 8'h00;
    cnt_q = 8'h00;
    sysref_o = 1'b0;
  end

  // Pulses never shorter than two clocks
  assign hi_w = (high_i < 8'h02) ? 8'h02 : high_i;
  assign busy_o = (left_q != 8'h00);

  // Low phase first, then high, for each requested pulse
  always @(posedge clk_i) begin
    if (start_i) begin
      left_q <= npulse_i;
      cnt_q <= 8'h00;
      sysref_o <= 1'b0;
    end else if (left_q != 8'h00) begin
      cnt_q <= cnt_q + 8'h01;
      if (!sysref_o && cnt_q + 8'h01 >= low_i) begin
        sysref_o <= 1'b1;
        cnt_q <= 8'h00;
      end else if (sysref_o && cnt_q + 8'h01 >= hi_w) begin
        sysref_o <= 1'b0;
        cnt_q <= 8'h00;
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule : srcap_ref_gen
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench of the reference capture block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic sysref, decim_active_i = 1'b0, sample_en_o, irq_o, busy;
  srcap_pkg::srcap_sync_s sync_o;
  logic [2:0] ctrl_bits_o, last_mark;
  logic start = 1'b0, rd_q = 1'b0, ref_q = 1'b0;
  logic [7:0] npulse = 8'h00, high = 8'h0A, nsync, nmark, n, lat0;
  logic [15:0] ent, lat;
  logic [15:0] exp_q[$];
  int num_errors = 0, total_checks = 0, cyc = 0, t_ref = 0;
  logic [15:0] adr[8] = '{srcap_pkg::ADDR_CLK_DIV, srcap_pkg::ADDR_SKEW_WIN,
    srcap_pkg::ADDR_TS_DELAY, srcap_pkg::ADDR_SH_MON,
    srcap_pkg::ADDR_CHIP_SYNC, srcap_pkg::ADDR_CB_FUNC_LO,
    srcap_pkg::ADDR_CB_FUNC_HI, srcap_pkg::ADDR_CB_COUNT};
  logic [7:0] msk[8] = '{8'h07, 8'h0F, 8'hFF, 8'h00, 8'h01, 8'h77, 8'h07,
    8'hC0};

  srcap_top i_srcap_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sysref_i(sysref),
    .decim_active_i(decim_active_i), .sync_o(sync_o),
    .ctrl_bits_o(ctrl_bits_o), .sample_en_o(sample_en_o), .irq_o(irq_o));
  srcap_ref_gen i_srcap_ref_gen (.clk_i(clk_i), .start_i(start),
    .npulse_i(npulse), .high_i(high), .low_i(8'h0C), .sysref_o(sysref),
    .busy_o(busy));

  // Clock of 8 ns period
  always #4 clk_i = ~clk_i;

  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    total_checks++;
    if (got !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read with expected value under a compare mask, noted in the queue
  task automatic rd(input logic [15:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd

  task automatic pulses(input logic [7:0] cnt, input logic [7:0] h);
    @(posedge clk_i);
    start <= 1'b1;
    npulse <= cnt;
    high <= h;
    @(posedge clk_i);
    start <= 1'b0;
    @(posedge clk_i);
    while (busy) @(posedge clk_i);
    repeat (15) @(posedge clk_i);
  endtask : pulses

  // Continuous train of three pulses, resync count within limits
  task automatic cont(input logic [7:0] h, input logic [7:0] w,
                      input logic [7:0] lo, input logic [7:0] hi);
    nsync = 8'h00;
    wr(srcap_pkg::ADDR_SKEW_WIN, w);
    pulses(8'h03, h);
    chk({7'h0, nsync >= lo && nsync <= hi}, 8'h01);
  endtask : cont

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Output watcher: read data, sync pulses, marks, timeout
  always @(posedge clk_i) begin
    cyc++;
    rd_q <= reg_rd_i;
    ref_q <= sysref;
    if (rd_q) begin
      ent = exp_q.pop_front();
      chk(reg_rdata_o & ent[15:8], ent[7:0]);
    end
    if (sysref && !ref_q) t_ref = cyc;
    if (sync_o != 4'h0) begin
      nsync++;
      chk({4'h0, sync_o}, 8'h0F);
    end
    if (ctrl_bits_o != 3'h0) begin
      nmark++;
      last_mark = ctrl_bits_o;
      lat = 16'(cyc - t_ref);
    end
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h92A5));
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (adr[i]) rd(adr[i], 8'h00, 8'hFF);
    rd(srcap_pkg::ADDR_LMFC_PER, srcap_pkg::RST_LMFC_PER, 8'hFF);
    foreach (adr[i]) wr(adr[i], 8'hFF);
    foreach (adr[i]) rd(adr[i], msk[i], 8'hFF);
    foreach (adr[i]) wr(adr[i], 8'h00);
    rd(16'h0200, 8'h00, 8'hFF);
    // Sample enable once every divider value plus one clocks
    wr(srcap_pkg::ADDR_CLK_DIV, 8'h03);
    n = 8'h00;
    repeat (16) begin
      @(posedge clk_i);
      if (sample_en_o) n++;
    end
    chk(n, 8'h04);
    wr(srcap_pkg::ADDR_CLK_DIV, 8'h00);
    $display("Test registers done");
    // Counted shot ignoring a random number of events
    n = 8'($urandom_range(2, 0));
    nsync = 8'h00;
    wr(srcap_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(srcap_pkg::ADDR_IGNORE_CNT, n);
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h04);
    pulses(n + 8'h02, 8'h0A);
    chk(nsync, 8'h01);
    rd(srcap_pkg::ADDR_REF_CTRL, 8'h00, 8'h06);
    rd(srcap_pkg::ADDR_SH_MON, 8'h88, 8'hFF);
    chk({7'h0, irq_o}, 8'h01);
    rd(srcap_pkg::ADDR_IRQ_STAT, 8'h01, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    $display("Test counted shot done");
    // Falling transition on the late clock, then reserved mode
    nsync = 8'h00;
    wr(srcap_pkg::ADDR_IGNORE_CNT, 8'h00);
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h1C);
    pulses(8'h01, 8'h0A);
    chk(nsync, 8'h01);
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h06);
    pulses(8'h01, 8'h0A);
    chk(nsync, 8'h01);
    // Short pulse leaves little hold margin
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h04);
    pulses(8'h01, 8'h03);
    rd(srcap_pkg::ADDR_SH_MON, 8'hC0, 8'hCF);
    $display("Test edges and margin done");
    // Continuous trains: aligned, late by one, early by one sample
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h02);
    cont(8'h14, 8'h00, 8'h00, 8'h01);
    cont(8'h15, 8'h01, 8'h01, 8'h02);
    cont(8'h13, 8'h04, 8'h01, 8'h02);
    $display("Test continuous done");
    // Timestamp marking with one control bit
    nsync = 8'h00;
    nmark = 8'h00;
    wr(srcap_pkg::ADDR_CHIP_SYNC, 8'h01);
    wr(srcap_pkg::ADDR_CB_COUNT, 8'h40);
    wr(srcap_pkg::ADDR_CB_FUNC_HI, 8'h05);
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h04);
    pulses(8'h01, 8'h0A);
    chk(nsync, 8'h00);
    chk({5'h0, last_mark}, 8'h04);
    lat0 = lat[7:0];
    wr(srcap_pkg::ADDR_TS_DELAY, 8'h03);
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h04);
    pulses(8'h01, 8'h0A);
    chk(lat[7:0] - lat0, 8'h03);
    // Three control bits all carrying the mark
    wr(srcap_pkg::ADDR_CB_COUNT, 8'hC0);
    wr(srcap_pkg::ADDR_CB_FUNC_LO, 8'h55);
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h04);
    pulses(8'h01, 8'h0A);
    chk({5'h0, last_mark}, 8'h07);
    chk(nmark, 8'h03);
    // No mark while decimating
    @(posedge clk_i);
    decim_active_i <= 1'b1;
    wr(srcap_pkg::ADDR_REF_CTRL, 8'h04);
    pulses(8'h01, 8'h0A);
    chk(nmark, 8'h03);
    chk(nsync, 8'h00);
    $display("Test timestamp done");
    repeat (3) @(posedge clk_i);
    stop_test();
  end
endmodule : tb
`default_nettype wire
